// ==== hdl/compact_alu_defines.vh ====
// Constants for the compact instruction logic, shift and multiply/divide unit
// Overview of operation
// - Equality test XORs rx with ry into register 24; rx unchanged.
// - Zero-minus subtracts ry from zero, 32-bit result, written to rx.
// - AND and XOR combine rx with ry; NOT inverts ry; all write rx.
// - Two moves copy between a compact register and any of 32 registers.
// - Immediate shifts use a 3-bit count; zero encodes a shift of eight.
// - Word shifts on 32 bits: left zero-fill, logical zero-fill, arithmetic sign-fill.
// - In 64-bit mode word shift results are sign-extended to 64 bits.
// - Variable word shifts count from rx low five bits, write ry.
// - Doubleword immediate shifts work on 64 bits with zero or sign fill.
// - Doubleword variable shifts count from rx low six bits, write ry.
// - Doubleword shifts need 64-bit or kernel mode, else reserved-instruction exception.
// - Signed multiply: low product word to bottom, high word to top.
// - Unsigned multiply splits the product into bottom and top likewise.
// - In 64-bit mode each multiply/divide half is sign-extended to 64 bits.
// - Divide rx by ry: quotient to bottom, remainder to top.
// - Zero divisor leaves undefined results; no overflow exception ever.
// - Read-top copies the top result register into rx.
// - Read-bottom copies the bottom result register into rx.
`ifndef COMPACT_ALU_DEFINES_VH
`define COMPACT_ALU_DEFINES_VH

// ***************************************************************
// Operation codes
// ***************************************************************
`define OP_EQUALITY_TEST_REGS       5'h00
`define OP_ZERO_MINUS_REG           5'h01
`define OP_AND                      5'h02
`define OP_OR                       5'h03
`define OP_XOR                      5'h04
`define OP_NOT                      5'h05
`define OP_MOVE_FROM_ANY_GPR        5'h06
`define OP_MOVE_TO_ANY_GPR          5'h07
`define OP_SHIFT_LEFT_IMM           5'h08
`define OP_SHIFT_RIGHT_ZERO_IMM     5'h09
`define OP_SHIFT_RIGHT_SIGN_IMM     5'h0A
`define OP_SHIFT_LEFT_VAR           5'h0B
`define OP_SHIFT_RIGHT_ZERO_VAR     5'h0C
`define OP_SHIFT_RIGHT_SIGN_VAR     5'h0D
`define OP_DWORD_SHIFT_LEFT_IMM     5'h0E
`define OP_DWORD_SHIFT_RIGHT_ZERO_IMM 5'h0F
`define OP_DWORD_SHIFT_RIGHT_SIGN_IMM 5'h10
`define OP_DWORD_SHIFT_LEFT_VAR     5'h11
`define OP_DWORD_SHIFT_RIGHT_ZERO_VAR 5'h12
`define OP_DWORD_SHIFT_RIGHT_SIGN_VAR 5'h13
`define OP_SIGNED_PRODUCT           5'h14
`define OP_UNSIGNED_PRODUCT         5'h15
`define OP_SIGNED_QUOTIENT          5'h16
`define OP_UNSIGNED_QUOTIENT        5'h17
`define OP_READ_PRODUCT_TOP         5'h18
`define OP_READ_PRODUCT_BOTTOM      5'h19

// ***************************************************************
// Fixed registers, counts and reset values
// ***************************************************************
`define TEST_RESULT_GPR             5'h18
`define IMM_ZERO_SHIFT_COUNT        6'h08
`define WORD_COUNT_BITS             5
`define DWORD_COUNT_BITS            6
`define DIV_STEPS                   6'h20
`define RESULT_RESET                64'h0000000000000000

`endif

// ==== hdl/word_divider.v ====
// Sequential 32-bit signed or unsigned divider, one quotient bit per clock
`timescale 1ns/1ns
`include "compact_alu_defines.vh"

module word_divider (
	input  wire        i_clk,
	input  wire        i_sys_rst,
	input  wire        i_start,
	input  wire        i_signed,
	input  wire [31:0] i_dividend,
	input  wire [31:0] i_divisor,
	output reg         o_done,
	output reg  [31:0] o_quot,
	output reg  [31:0] o_rem
);

	localparam ST_IDLE = 1'b0;
	localparam ST_RUN  = 1'b1;

	reg         state_q;
	reg  [5:0]  count_q;
	reg  [31:0] rem_q;
	reg  [31:0] quot_q;
	reg  [31:0] div_q;
	reg         neg_quot_q;
	reg         neg_rem_q;

	wire        dvd_neg;
	wire        dvs_neg;
	wire [31:0] dvd_mag;
	wire [31:0] dvs_mag;
	wire [32:0] shifted;
	wire [32:0] trial;

	// Magnitudes first; signs are restored once the loop ends
	assign dvd_neg = i_signed & i_dividend[31];
	assign dvs_neg = i_signed & i_divisor[31];
	assign dvd_mag = dvd_neg ? (32'h0 - i_dividend) : i_dividend;
	assign dvs_mag = dvs_neg ? (32'h0 - i_divisor) : i_divisor;

	// Restoring step: bring down one dividend bit, try to subtract
	assign shifted = {rem_q, quot_q[31]};
	assign trial   = shifted - {1'b0, div_q};

	// Divide loop; a zero divisor simply runs and yields junk
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			state_q    <= ST_IDLE;
			count_q    <= 6'h00;
			rem_q      <= 32'h00000000;
			quot_q     <= 32'h00000000;
			div_q      <= 32'h00000000;
			neg_quot_q <= 1'b0;
			neg_rem_q  <= 1'b0;
			o_done     <= 1'b0;
			o_quot     <= 32'h00000000;
			o_rem      <= 32'h00000000;
		end else begin
			o_done <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					if (i_start) begin
						state_q    <= ST_RUN;
						count_q    <= `DIV_STEPS;
						rem_q      <= 32'h00000000;
						quot_q     <= dvd_mag;
						div_q      <= dvs_mag;
						neg_quot_q <= dvd_neg ^ dvs_neg;
						neg_rem_q  <= dvd_neg;
					end
				end
				ST_RUN: begin
					if (count_q == 6'h00) begin
						// Quotient sign from both operands, remainder from dividend
						state_q <= ST_IDLE;
						o_done  <= 1'b1;
						o_quot  <= neg_quot_q ? (32'h0 - quot_q) : quot_q;
						o_rem   <= neg_rem_q ? (32'h0 - rem_q) : rem_q;
					end else begin
						count_q <= count_q - 6'h01;
						if (!trial[32]) begin
							rem_q  <= trial[31:0];
							quot_q <= {quot_q[30:0], 1'b1};
						end else begin
							rem_q  <= shifted[31:0];
							quot_q <= {quot_q[30:0], 1'b0};
						end
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

endmodule

// ==== hdl/compact_alu.v ====
// Execution unit: compare, negate, logic, moves, shifts, multiply and divide
`timescale 1ns/1ns
`include "compact_alu_defines.vh"

module compact_alu (
	input  wire        i_clk,
	input  wire        i_sys_rst,
	input  wire        i_valid,
	input  wire [4:0]  i_op,
	input  wire [4:0]  i_rx_idx,
	input  wire [4:0]  i_ry_idx,
	input  wire [4:0]  i_any_idx,
	input  wire [63:0] i_rx_val,
	input  wire [63:0] i_ry_val,
	input  wire [63:0] i_any_val,
	input  wire [2:0]  i_imm,
	input  wire        i_mode64,
	input  wire        i_kernel,
	output wire        o_ready,
	output reg         o_wr_en,
	output reg  [4:0]  o_wr_idx,
	output reg  [63:0] o_wr_data,
	output reg         o_rsv_exc,
	output reg  [63:0] o_product_top,
	output reg  [63:0] o_product_bottom
);

	// ***************************************************************
	// State and declarations
	// ***************************************************************
	localparam ST_IDLE     = 1'b0;
	localparam ST_DIV_WAIT = 1'b1;

	reg         state_q;
	reg         div_mode64_q;

	reg         wr_en_d;
	reg  [4:0]  wr_idx_d;
	reg  [63:0] wr_data_d;
	reg         rsv_exc_d;
	reg         prod_we_d;
	reg  [63:0] prod_top_d;
	reg  [63:0] prod_bottom_d;
	reg         div_start_d;
	reg         div_signed_d;

	wire        take;
	wire        dword_ok;
	wire [5:0]  imm_count;
	wire [4:0]  word_imm_cnt;
	wire [4:0]  word_var_cnt;
	wire [5:0]  dword_var_cnt;
	wire [31:0] ry_word;
	wire [31:0] rx_word;
	wire [31:0] neg_word;

	wire [31:0] sll_imm_w;
	wire [31:0] srl_imm_w;
	wire [31:0] sra_imm_w;
	wire [31:0] sll_var_w;
	wire [31:0] srl_var_w;
	wire [31:0] sra_var_w;
	wire [63:0] dword_shift_left_imm_imm;
	wire [63:0] dword_shift_right_zero_imm_imm;
	wire [63:0] dword_shift_right_sign_imm_imm;
	wire [63:0] dword_shift_left_imm_var;
	wire [63:0] dword_shift_right_zero_imm_var;
	wire [63:0] dword_shift_right_sign_imm_var;

	wire signed [63:0] prod_signed;
	wire        [63:0] prod_unsigned;

	wire        div_done;
	wire [31:0] div_quot;
	wire [31:0] div_rem;

	// Widen a 32-bit result: sign-extend in 64-bit mode, zero upper half otherwise
	function [63:0] ext32;
		input [31:0] v;
		input        m64;
		begin
			ext32 = m64 ? {{32{v[31]}}, v} : {32'h00000000, v};
		end
	endfunction

	// ***************************************************************
	// Handshake
	// ***************************************************************
	// Divide occupies the unit; everything else finishes in one cycle
	assign o_ready = (state_q == ST_IDLE);
	assign take    = i_valid & o_ready;

	// Doubleword ops are legal in 64-bit mode or in kernel mode
	assign dword_ok = i_mode64 | i_kernel;

	// ***************************************************************
	// Operand preparation
	// ***************************************************************
	assign rx_word = i_rx_val[31:0];
	assign ry_word = i_ry_val[31:0];

	// Encoded zero means eight; other codes shift by their value
	assign imm_count     = (i_imm == 3'h0) ? `IMM_ZERO_SHIFT_COUNT : {3'h0, i_imm};
	assign word_imm_cnt  = imm_count[4:0];
	// Count from the low five or six bits of rx
	assign word_var_cnt  = i_rx_val[`WORD_COUNT_BITS-1:0];
	assign dword_var_cnt = i_rx_val[`DWORD_COUNT_BITS-1:0];

	// Negation on the low word only, so the result is 32 bits wide
	assign neg_word = 32'h00000000 - ry_word;

	// ***************************************************************
	// Shifters
	// ***************************************************************
	// Word shifts: zero fill, zero fill, sign fill
	assign sll_imm_w = ry_word << word_imm_cnt;
	assign srl_imm_w = ry_word >> word_imm_cnt;
	assign sra_imm_w = $signed(ry_word) >>> word_imm_cnt;
	// Variable forms use the same fills
	assign sll_var_w = ry_word << word_var_cnt;
	assign srl_var_w = ry_word >> word_var_cnt;
	assign sra_var_w = $signed(ry_word) >>> word_var_cnt;

	// Doubleword shifts on the full register
	assign dword_shift_left_imm_imm = i_ry_val << imm_count;
	assign dword_shift_right_zero_imm_imm = i_ry_val >> imm_count;
	assign dword_shift_right_sign_imm_imm = $signed(i_ry_val) >>> imm_count;
	assign dword_shift_left_imm_var = i_ry_val << dword_var_cnt;
	assign dword_shift_right_zero_imm_var = i_ry_val >> dword_var_cnt;
	assign dword_shift_right_sign_imm_var = $signed(i_ry_val) >>> dword_var_cnt;

	// ***************************************************************
	// Multiplier
	// ***************************************************************
	// Single-cycle products of the low words; area traded for latency
	assign prod_signed   = $signed(rx_word) * $signed(ry_word);
	assign prod_unsigned = rx_word * ry_word;

	// ***************************************************************
	// Divider
	// ***************************************************************
	word_divider u_divider (
		.i_clk      (i_clk),
		.i_sys_rst  (i_sys_rst),
		.i_start    (div_start_d),
		.i_signed   (div_signed_d),
		.i_dividend (rx_word),
		.i_divisor  (ry_word),
		.o_done     (div_done),
		.o_quot     (div_quot),
		.o_rem      (div_rem)
	);

	// ***************************************************************
	// Operation decode and result select
	// ***************************************************************
	// One case on the operation picks destination, data and side effects
	always @* begin
		wr_en_d       = 1'b0;
		wr_idx_d      = i_rx_idx;
		wr_data_d     = `RESULT_RESET;
		rsv_exc_d     = 1'b0;
		prod_we_d     = 1'b0;
		prod_top_d    = o_product_top;
		prod_bottom_d = o_product_bottom;
		div_start_d   = 1'b0;
		div_signed_d  = 1'b0;
		if (take) begin
			case (i_op)
				`OP_EQUALITY_TEST_REGS: begin
					wr_en_d   = 1'b1;
					wr_idx_d  = `TEST_RESULT_GPR;
					wr_data_d = i_rx_val ^ i_ry_val;
				end
				`OP_ZERO_MINUS_REG: begin
					wr_en_d   = 1'b1;
					wr_data_d = ext32(neg_word, i_mode64);
				end
				`OP_AND: begin
					wr_en_d   = 1'b1;
					wr_data_d = i_rx_val & i_ry_val;
				end
				`OP_OR: begin
					wr_en_d   = 1'b1;
					wr_data_d = i_rx_val | i_ry_val;
				end
				`OP_XOR: begin
					wr_en_d   = 1'b1;
					wr_data_d = i_rx_val ^ i_ry_val;
				end
				`OP_NOT: begin
					wr_en_d   = 1'b1;
					wr_data_d = ~i_ry_val;
				end
				`OP_MOVE_FROM_ANY_GPR: begin
					wr_en_d   = 1'b1;
					wr_idx_d  = i_ry_idx;
					wr_data_d = i_any_val;
				end
				`OP_MOVE_TO_ANY_GPR: begin
					wr_en_d   = 1'b1;
					wr_idx_d  = i_any_idx;
					wr_data_d = i_rx_val;
				end
				`OP_SHIFT_LEFT_IMM: begin
					wr_en_d   = 1'b1;
					wr_data_d = ext32(sll_imm_w, i_mode64);
				end
				`OP_SHIFT_RIGHT_ZERO_IMM: begin
					wr_en_d   = 1'b1;
					wr_data_d = ext32(srl_imm_w, i_mode64);
				end
				`OP_SHIFT_RIGHT_SIGN_IMM: begin
					wr_en_d   = 1'b1;
					wr_data_d = ext32(sra_imm_w, i_mode64);
				end
				`OP_SHIFT_LEFT_VAR: begin
					wr_en_d   = 1'b1;
					wr_idx_d  = i_ry_idx;
					wr_data_d = ext32(sll_var_w, i_mode64);
				end
				`OP_SHIFT_RIGHT_ZERO_VAR: begin
					wr_en_d   = 1'b1;
					wr_idx_d  = i_ry_idx;
					wr_data_d = ext32(srl_var_w, i_mode64);
				end
				`OP_SHIFT_RIGHT_SIGN_VAR: begin
					wr_en_d   = 1'b1;
					wr_idx_d  = i_ry_idx;
					wr_data_d = ext32(sra_var_w, i_mode64);
				end
				`OP_DWORD_SHIFT_LEFT_IMM: begin
					// Only this immediate doubleword form writes rx
					wr_en_d   = dword_ok;
					rsv_exc_d = ~dword_ok;
					wr_data_d = dword_shift_left_imm_imm;
				end
				`OP_DWORD_SHIFT_RIGHT_ZERO_IMM: begin
					wr_en_d   = dword_ok;
					rsv_exc_d = ~dword_ok;
					wr_idx_d  = i_ry_idx;
					wr_data_d = dword_shift_right_zero_imm_imm;
				end
				`OP_DWORD_SHIFT_RIGHT_SIGN_IMM: begin
					wr_en_d   = dword_ok;
					rsv_exc_d = ~dword_ok;
					wr_idx_d  = i_ry_idx;
					wr_data_d = dword_shift_right_sign_imm_imm;
				end
				`OP_DWORD_SHIFT_LEFT_VAR: begin
					wr_en_d   = dword_ok;
					rsv_exc_d = ~dword_ok;
					wr_idx_d  = i_ry_idx;
					wr_data_d = dword_shift_left_imm_var;
				end
				`OP_DWORD_SHIFT_RIGHT_ZERO_VAR: begin
					wr_en_d   = dword_ok;
					rsv_exc_d = ~dword_ok;
					wr_idx_d  = i_ry_idx;
					wr_data_d = dword_shift_right_zero_imm_var;
				end
				`OP_DWORD_SHIFT_RIGHT_SIGN_VAR: begin
					wr_en_d   = dword_ok;
					rsv_exc_d = ~dword_ok;
					wr_idx_d  = i_ry_idx;
					wr_data_d = dword_shift_right_sign_imm_var;
				end
				`OP_SIGNED_PRODUCT: begin
					// Never an overflow exception from the product
					prod_we_d     = 1'b1;
					prod_bottom_d = ext32(prod_signed[31:0], i_mode64);
					prod_top_d    = ext32(prod_signed[63:32], i_mode64);
				end
				`OP_UNSIGNED_PRODUCT: begin
					prod_we_d     = 1'b1;
					prod_bottom_d = ext32(prod_unsigned[31:0], i_mode64);
					prod_top_d    = ext32(prod_unsigned[63:32], i_mode64);
				end
				`OP_SIGNED_QUOTIENT: begin
					div_start_d  = 1'b1;
					div_signed_d = 1'b1;
				end
				`OP_UNSIGNED_QUOTIENT: begin
					div_start_d  = 1'b1;
				end
				`OP_READ_PRODUCT_TOP: begin
					wr_en_d   = 1'b1;
					wr_data_d = o_product_top;
				end
				`OP_READ_PRODUCT_BOTTOM: begin
					wr_en_d   = 1'b1;
					wr_data_d = o_product_bottom;
				end
				default: begin
					// Unassigned codes do nothing; the decoder traps them
					wr_en_d = 1'b0;
				end
			endcase
		end
	end

	// ***************************************************************
	// Write-back and result pair registers
	// ***************************************************************
	// Write port is registered, so results appear one cycle after the take
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_wr_en   <= 1'b0;
			o_wr_idx  <= 5'h00;
			o_wr_data <= `RESULT_RESET;
			o_rsv_exc <= 1'b0;
		end else begin
			o_wr_en   <= wr_en_d;
			o_wr_idx  <= wr_idx_d;
			o_wr_data <= wr_data_d;
			o_rsv_exc <= rsv_exc_d;
		end
	end

	// Pair updates at once for products, or when the divider reports done
	always @(posedge i_clk) begin
		if (i_sys_rst) begin
			state_q          <= ST_IDLE;
			div_mode64_q     <= 1'b0;
			o_product_top    <= `RESULT_RESET;
			o_product_bottom <= `RESULT_RESET;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (prod_we_d) begin
						o_product_top    <= prod_top_d;
						o_product_bottom <= prod_bottom_d;
					end
					if (div_start_d) begin
						state_q      <= ST_DIV_WAIT;
						div_mode64_q <= i_mode64; // Mode held for the late write
					end
				end
				ST_DIV_WAIT: begin
					if (div_done) begin
						state_q          <= ST_IDLE;
						o_product_bottom <= ext32(div_quot, div_mode64_q);
						o_product_top    <= ext32(div_rem, div_mode64_q);
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

endmodule

// ==== sim/gpr_file_model.sv ====
// Register file model standing in for the core decode and register read side
`timescale 1ns/1ns
module gpr_file_model (
	input  wire        i_clk,
	input  wire [4:0]  i_rx_idx,
	input  wire [4:0]  i_ry_idx,
	input  wire [4:0]  i_any_idx,
	input  wire        i_wr_en,
	input  wire [4:0]  i_wr_idx,
	input  wire [63:0] i_wr_data,
	output wire [63:0] o_rx_val,
	output wire [63:0] o_ry_val,
	output wire [63:0] o_any_val
);
	reg [63:0] regs_q [0:31];
	// Read ports are combinational, as the file feeds execute directly
	assign o_rx_val = regs_q[i_rx_idx];
	assign o_ry_val = regs_q[i_ry_idx];
	assign o_any_val = regs_q[i_any_idx];
	// Write-back lands at the edge; bench loads operands between edges
	always @(posedge i_clk) begin
		if (i_wr_en) begin
			regs_q[i_wr_idx] <= i_wr_data;
		end
	end
endmodule

// ==== sim/compact_alu_monitor.sv ====
// Port checker for the execution unit
`timescale 1ns/1ns
`include "compact_alu_defines.vh"
module alu_monitor (
	input wire        i_clk,
	input wire        i_sys_rst,
	input wire        i_valid,
	input wire [4:0]  i_op,
	input wire [4:0]  i_rx_idx,
	input wire [63:0] i_rx_val,
	input wire [63:0] i_ry_val,
	input wire [2:0]  i_imm,
	input wire        i_mode64,
	input wire        i_kernel,
	input wire        o_ready,
	input wire        o_wr_en,
	input wire [4:0]  o_wr_idx,
	input wire [63:0] o_wr_data,
	input wire        o_rsv_exc,
	input wire [63:0] o_product_top,
	input wire [63:0] o_product_bottom
);
	// ****************************************
	// Decoded conditions and reference values
	// ****************************************
	wire        take = i_valid & o_ready;
	wire        dw = (i_op >= `OP_DWORD_SHIFT_LEFT_IMM) &&
		(i_op <= `OP_DWORD_SHIFT_RIGHT_SIGN_VAR);
	wire        bad = take & dw & ~i_mode64 & ~i_kernel;
	wire        dv = take && (i_op == `OP_SIGNED_QUOTIENT || i_op == `OP_UNSIGNED_QUOTIENT);
	wire [63:0] xr = i_rx_val ^ i_ry_val;
	wire [63:0] uprod = {32'h0, i_rx_val[31:0]} * {32'h0, i_ry_val[31:0]};
	wire [31:0] sl8 = {i_ry_val[23:0], 8'h00};
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	// Every assertion but AST_DIV_BUSY ties a registered result to the taken request; that one checks the ready timing of a divide
	AST_CMP_DEST: assert property (take && i_op == `OP_EQUALITY_TEST_REGS |=> o_wr_en &&
		o_wr_idx == `TEST_RESULT_GPR && o_wr_data == $past(xr)) else $error("compare bad");
	AST_NOT_DATA: assert property (take && i_op == `OP_NOT |=>
		o_wr_data == ~$past(i_ry_val) && o_wr_idx == $past(i_rx_idx)) else $error("not bad");
	AST_OR_DATA: assert property (take && i_op == `OP_OR |=>
		o_wr_data == ($past(i_rx_val) | $past(i_ry_val))) else $error("or bad");
	AST_IMM_EIGHT: assert property (take && i_op == `OP_SHIFT_LEFT_IMM && i_imm == 3'h0 &&
		!i_mode64 |=> o_wr_data == {32'h0, $past(sl8)}) else $error("count eight bad");
	AST_WORD_SEXT: assert property (take && i_op == `OP_SHIFT_RIGHT_SIGN_IMM && i_mode64 |=>
		o_wr_data[63:32] == {32{o_wr_data[31]}}) else $error("sign extend bad");
	AST_RSV_RAISE: assert property (bad |=> o_rsv_exc && !o_wr_en)
		else $error("exception missing");
	AST_RSV_CAUSE: assert property (o_rsv_exc |-> $past(bad))
		else $error("stray exception");
	AST_MUL_SPLIT: assert property (take && i_op == `OP_UNSIGNED_PRODUCT && !i_mode64 |=>
		{o_product_top, o_product_bottom} == {32'h0, $past(uprod[63:32]), 32'h0,
		$past(uprod[31:0])}) else $error("product split bad");
	AST_DIV_BUSY: assert property (dv |=> !o_ready [*8] ##[1:40] o_ready)
		else $error("divide timing bad");
	AST_READ_TOP: assert property (take && i_op == `OP_READ_PRODUCT_TOP |=>
		o_wr_en && o_wr_data == $past(o_product_top)) else $error("read top bad");
	AST_READ_BOTTOM: assert property (take && i_op == `OP_READ_PRODUCT_BOTTOM |=>
		o_wr_en && o_wr_data == $past(o_product_bottom)) else $error("read bottom bad");
	// Main scenarios seen at least once
	cover property (dv);
	cover property (o_rsv_exc);
	cover property (take && i_op == `OP_SIGNED_PRODUCT);
endmodule
bind compact_alu alu_monitor mon_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_valid(i_valid),
	.i_op(i_op), .i_rx_idx(i_rx_idx), .i_rx_val(i_rx_val), .i_ry_val(i_ry_val),
	.i_imm(i_imm), .i_mode64(i_mode64), .i_kernel(i_kernel), .o_ready(o_ready),
	.o_wr_en(o_wr_en), .o_wr_idx(o_wr_idx), .o_wr_data(o_wr_data), .o_rsv_exc(o_rsv_exc),
	.o_product_top(o_product_top), .o_product_bottom(o_product_bottom));

// ==== sim/compact_alu_tb.sv ====
// Self-checking bench for the execution unit with a register file model
`timescale 1ns/1ns
`include "compact_alu_defines.vh"
module compact_alu_tb;
	localparam [63:0] A = 64'hFFFFFFFF800000F1;
	localparam [63:0] B = 64'h000000000F0F1234;
	localparam [63:0] C = 64'h0123456789ABCDEF;
	localparam [63:0] S = 64'hFFFFFFFF92345678;
	reg               i_clk, i_sys_rst, i_valid, i_mode64, i_kernel;
	reg  [4:0]        i_op;
	reg  [4:0]        any_idx;
	reg  [2:0]        i_imm;
	wire [63:0]       rx_val, ry_val, any_val, o_wr_data, o_product_top, o_product_bottom;
	wire [4:0]        o_wr_idx;
	wire              o_ready, o_wr_en, o_rsv_exc;
	integer           err_total, compares, i, k;
	reg  [63:0]       p;
	compact_alu dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_valid(i_valid), .i_op(i_op),
		.i_rx_idx(5'h01), .i_ry_idx(5'h02), .i_any_idx(any_idx), .i_rx_val(rx_val),
		.i_ry_val(ry_val), .i_any_val(any_val), .i_imm(i_imm), .i_mode64(i_mode64),
		.i_kernel(i_kernel), .o_ready(o_ready), .o_wr_en(o_wr_en), .o_wr_idx(o_wr_idx),
		.o_wr_data(o_wr_data), .o_rsv_exc(o_rsv_exc), .o_product_top(o_product_top),
		.o_product_bottom(o_product_bottom));
	gpr_file_model rf_u (.i_clk(i_clk), .i_rx_idx(5'h01), .i_ry_idx(5'h02), .i_any_idx(any_idx),
		.i_wr_en(o_wr_en), .i_wr_idx(o_wr_idx), .i_wr_data(o_wr_data), .o_rx_val(rx_val),
		.o_ry_val(ry_val), .o_any_val(any_val));
	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end
	// ****************************************
	// Reference arithmetic and compare helpers
	// ****************************************
	function [63:0] sx(input [31:0] v, input m);
		sx = m ? {{32{v[31]}}, v} : {32'h0, v};
	endfunction
	function [31:0] wsh(input integer t, input [31:0] v, input [5:0] n);
		if (t == 0) wsh = v << n;
		else if (t == 1) wsh = v >> n;
		else wsh = $signed(v) >>> n;
	endfunction
	function [63:0] dsh(input integer t, input [63:0] v, input [5:0] n);
		if (t == 0) dsh = v << n;
		else if (t == 1) dsh = v >> n;
		else dsh = $signed(v) >>> n;
	endfunction
	task print_verdict;
		begin
			if (err_total == 0 && compares > 0) $display("NO MISMATCHES");
			else $display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	task chk_val(input [63:0] got, input [63:0] exp);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				err_total = err_total + 1;
				$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task chk_bit(input got, input exp);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				err_total = err_total + 1;
				$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	// Bounded wait; a divide must finish well inside sixty cycles
	task wait_ready;
		integer n;
		begin
			n = 0;
			while (o_ready !== 1'b1) begin
				n = n + 1;
				if (n > 60) begin
					err_total = err_total + 1;
					print_verdict;
				end
				@(posedge i_clk);
				#1;
			end
		end
	endtask
	// Operands loaded after the edge so the previous write-back cannot clobber them
	task issue(input [4:0] op, input [2:0] imm, input m, input kr, input [63:0] a, b);
		begin
			@(posedge i_clk);
			#1;
			wait_ready;
			rf_u.regs_q[1] = a;
			rf_u.regs_q[2] = b;
			i_valid = 1'b1;
			i_op = op;
			i_imm = imm;
			i_mode64 = m;
			i_kernel = kr;
			@(posedge i_clk);
			#1;
			i_valid = 1'b0;
		end
	endtask
	task ex(input [63:0] a, b, input [4:0] op, input [2:0] imm, input m, kr,
		input [4:0] ei, input [63:0] ed);
		begin
			issue(op, imm, m, kr, a, b);
			chk_bit(o_wr_en, 1'b1);
			chk_val({59'h0, o_wr_idx}, {59'h0, ei});
			chk_val(o_wr_data, ed);
		end
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task t_logic;
		begin
			ex(A, B, `OP_EQUALITY_TEST_REGS, 3'h0, 1, 0, `TEST_RESULT_GPR, A ^ B);
			@(posedge i_clk);
			#1;
			chk_val(rf_u.regs_q[1], A);
			ex(A, B, `OP_ZERO_MINUS_REG, 3'h0, 1, 0, 5'h01, sx(32'h0 - B[31:0], 1));
			ex(A, S, `OP_ZERO_MINUS_REG, 3'h0, 0, 0, 5'h01, sx(32'h0 - S[31:0], 0));
			ex(A, B, `OP_AND, 3'h0, 1, 0, 5'h01, A & B);
			ex(A, B, `OP_XOR, 3'h0, 0, 0, 5'h01, A ^ B);
			ex(A, B, `OP_NOT, 3'h0, 1, 0, 5'h01, ~B);
			// Top register index, so the full five-bit range is reached
			any_idx = 5'h1F;
			rf_u.regs_q[31] = C;
			ex(A, B, `OP_MOVE_FROM_ANY_GPR, 3'h0, 1, 0, 5'h02, C);
			ex(A, B, `OP_MOVE_TO_ANY_GPR, 3'h0, 1, 0, 5'h1F, A);
		end
	endtask
	// Every count 0..7 for each immediate kind, alternating the word-result mode
	task t_shift;
		begin
			for (k = 0; k < 3; k = k + 1) begin
				for (i = 0; i < 8; i = i + 1) begin
					ex(A, S, `OP_SHIFT_LEFT_IMM + k, i, i[0], 0, 5'h01, sx(wsh(k, S[31:0],
						(i == 0) ? 6'h08 : i), i[0]));
					ex(A, S, `OP_DWORD_SHIFT_LEFT_IMM + k, i, i[0], ~i[0], (k == 0) ? 5'h01 :
						5'h02, dsh(k, S, (i == 0) ? 6'h08 : i));
				end
				ex(64'hE5, S, `OP_SHIFT_LEFT_VAR + k, 3'h0, k[0], 0, 5'h02,
					sx(wsh(k, S[31:0], 6'h05), k[0]));
				ex(64'hC7, S, `OP_DWORD_SHIFT_LEFT_VAR + k, 3'h0, 0, 1, 5'h02, dsh(k, S, 6'h07));
			end
		end
	endtask
	task t_rsv;
		begin
			for (k = 0; k < 6; k = k + 1) begin
				issue(`OP_DWORD_SHIFT_LEFT_IMM + k, 3'h3, 0, 0, A, S);
				chk_bit(o_rsv_exc, 1'b1);
				chk_bit(o_wr_en, 1'b0);
			end
		end
	endtask
	// Reads follow at once; two logic ops keep the spacing before the next product
	task t_mul;
		begin
			for (k = 0; k < 2; k = k + 1) begin
				// Signed in 64-bit mode, unsigned in 32-bit mode
				issue(`OP_SIGNED_PRODUCT + k, 3'h0, ~k[0], 0, A, S);
				if (k == 0) p = $signed(A[31:0]) * $signed(S[31:0]);
				else p = A[31:0] * S[31:0];
				chk_val(o_product_bottom, sx(p[31:0], ~k[0]));
				chk_val(o_product_top, sx(p[63:32], ~k[0]));
				ex(A, S, `OP_READ_PRODUCT_TOP, 3'h0, 1, 0, 5'h01, sx(p[63:32], ~k[0]));
				ex(A, S, `OP_READ_PRODUCT_BOTTOM, 3'h0, 1, 0, 5'h01, sx(p[31:0], ~k[0]));
				ex(A, B, `OP_OR, 3'h0, 1, 0, 5'h01, A | B);
				ex(B, S, `OP_OR, 3'h0, 1, 0, 5'h01, B | S);
			end
		end
	endtask
	task t_div;
		begin
			issue(`OP_SIGNED_QUOTIENT, 3'h0, 1, 0, 64'hFFFFFFFFFFFFFF9C, 64'h7);
			wait_ready;
			chk_val(o_product_bottom, sx($signed(32'hFFFFFF9C) / 7, 1));
			chk_val(o_product_top, sx($signed(32'hFFFFFF9C) % 7, 1));
			issue(`OP_UNSIGNED_QUOTIENT, 3'h0, 0, 0, 64'hFFFFFF9C, 64'h7);
			wait_ready;
			chk_val(o_product_bottom, {32'h0, 32'hFFFFFF9C / 32'h7});
			chk_val(o_product_top, {32'h0, 32'hFFFFFF9C % 32'h7});
			issue(`OP_UNSIGNED_QUOTIENT, 3'h0, 0, 0, A, 64'h0);
			chk_bit(o_rsv_exc, 1'b0);
			wait_ready;
			issue(`OP_SIGNED_QUOTIENT, 3'h0, 0, 0, 64'h80000000, 64'hFFFFFFFF);
			chk_bit(o_rsv_exc, 1'b0);
			wait_ready;
		end
	endtask
	initial begin
		err_total = 0;
		compares = 0;
		i_sys_rst = 1'b1;
		i_valid = 1'b0;
		i_op = 5'h00;
		i_imm = 3'h0;
		i_mode64 = 1'b0;
		i_kernel = 1'b0;
		any_idx = 5'h09;
		repeat (2) @(posedge i_clk);
		#1;
		i_sys_rst = 1'b0;
		chk_bit(o_ready, 1'b1);
		chk_val(o_product_top, `RESULT_RESET);
		t_logic;
		t_shift;
		t_rsv;
		t_mul;
		t_div;
		print_verdict;
	end
endmodule
